/* File: hdl/bank_addr_pkg.sv */
// Constants and types for the banked data address select block
// What this block does
// - Access bank joins lowest 96 bytes of bank 0 and highest 160 of bank 15.
// - One access bit per instruction picks bank register bank or access bank.
// - With access bit zero, low access region is followed by high region.
// - Sixteen banks; bank register bits 3:0 form address bits 11:8.
// - Bank register bits 7:4 read zero and ignore writes.
// - Unimplemented bank reads zero, drops writes, flags still update.
// - Each implemented bank, at most banks 0 to 14, spans 256 byte offsets of static RAM.
// - Full-address move bypasses bank register, uses its 12-bit address.
// - Special function registers sit in the high access region.
// - Unimplemented special function register addresses read zero.
package bank_addr_pkg;

    // Address geometry
    localparam int          ADDR_W            = 12;
    localparam int          OFS_W             = 8;
    localparam int          BANK_W            = 4;
    localparam int          NUM_BANKS         = 16;
    localparam int          BANK_BYTES        = 256;
    localparam int          LOW_ACCESS_BYTES  = 96;
    localparam int          HIGH_ACCESS_BYTES = 160;
    localparam logic [7:0]  LOW_ACCESS_LIMIT  = 8'h60;
    localparam logic [3:0]  LOW_ACCESS_BANK   = 4'h0;
    localparam logic [3:0]  HIGH_ACCESS_BANK  = 4'hf;

    // Bank register layout
    localparam int          BANK_FIELD_LSB    = 0;
    localparam logic [7:0]  BANK_NUMBER_RST   = 8'h00;

    // Register offsets on the bus
    localparam logic [7:0]  REG_BANK_NUMBER   = 8'h00;
    localparam logic [7:0]  REG_LAST_ACCESS   = 8'h04;
    localparam logic [7:0]  REG_OP_COUNT      = 8'h08;

    // Last access status field positions
    localparam int          LAST_ADDR_LSB     = 0;
    localparam int          LAST_UNIMPL_BIT   = 16;
    localparam int          LAST_ACCESS_BIT   = 17;
    localparam int          LAST_FULL_BIT     = 18;
    localparam int          LAST_WRITE_BIT    = 19;
    localparam logic [31:0] LAST_ACCESS_RST   = 32'h0000_0000;
    localparam logic [15:0] OP_COUNT_RST      = 16'h0000;

    // Bus answers
    localparam logic [1:0]  RESP_OKAY         = 2'b00;
    localparam logic [1:0]  RESP_SLVERR       = 2'b10;

    // Write channel states
    typedef enum logic [0:0] {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;

endpackage

/* File: hdl/bank_ram.sv */
// Byte-wide static RAM for the implemented banks
`timescale 1ns/100ps
`default_nettype none
module bank_ram #(
    parameter int DEPTH  = 3840,
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [7:0]        wdata,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [7:0]        rdata
);

    logic [7:0] mem [DEPTH];

    // Elaboration check on depth
    initial begin
        if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin
            $error("bank_ram depth out of range");
        end
    end

    // Write port and registered read port
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule
`default_nettype wire

/* File: hdl/banked_data_address_select.sv */
// Banked data address formation with bank register and bus slave
`timescale 1ns/100ps
`default_nettype none
module banked_data_address_select
    import bank_addr_pkg::*;
#(
    parameter int         IMPL_BANKS = 15,
    parameter int         AXI_ADDR_W = 8,
    parameter logic [11:0] BANK_SFR_ADDR = 12'hf80
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Register bus write address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // Register bus write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // Register bus write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // Register bus read address
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // Register bus read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Operand access from the instruction decoder
    input  wire logic                  op_valid,
    input  wire logic                  op_access,
    input  wire logic [7:0]            op_offset,
    input  wire logic                  op_full,
    input  wire logic [11:0]           op_full_addr,
    input  wire logic                  op_write,
    input  wire logic [7:0]            op_wdata,
    // Bank load from the decoder
    input  wire logic                  load_bank_literal,
    input  wire logic [7:0]            load_bank_value,
    // Operand answer
    output logic [11:0]                eff_addr,
    output logic                       rd_valid,
    output logic [7:0]                 rd_data,
    output logic                       unimpl_hit,
    output logic [7:0]                 bank_number
);

    localparam int RAM_DEPTH = IMPL_BANKS * BANK_BYTES;

    // Elaboration checks on parameters
    initial begin
        if (IMPL_BANKS < 1 || IMPL_BANKS > NUM_BANKS - 1) begin
            $error("IMPL_BANKS must be 1 to 15");
        end
        if (AXI_ADDR_W < 4 || AXI_ADDR_W > 8) begin
            $error("AXI_ADDR_W must be 4 to 8");
        end
        if (BANK_SFR_ADDR[11:8] != HIGH_ACCESS_BANK ||
            BANK_SFR_ADDR[7:0] < LOW_ACCESS_LIMIT) begin
            $error("BANK_SFR_ADDR must lie in the high access region");
        end
    end

    // True where the address lands in implemented static RAM
    function automatic logic is_ram(input logic [11:0] a);
        is_ram = ({28'h0, a[11:8]} < 32'(IMPL_BANKS));
    endfunction

    // True where the address lands in the special function area
    function automatic logic is_sfr(input logic [11:0] a);
        is_sfr = (a[11:8] == HIGH_ACCESS_BANK) &&
                 (a[7:0] >= LOW_ACCESS_LIMIT);
    endfunction

    // Registers
    logic [3:0]  bank_r;
    logic [3:0]  bank_nxt;
    logic [31:0] last_r;
    logic [15:0] count_r;
    logic [11:0] eff_addr_r;
    logic        stage1_r;
    logic        s1_ram_r;
    logic        s1_bank_r;
    logic        s1_unimpl_r;
    logic        rd_valid_r;
    logic [7:0]  rd_data_r;
    logic        unimpl_r;
    logic [7:0]  ram_rdata;

    // Bus registers
    wr_state_t             wr_state_r;
    logic                  aw_held_r;
    logic                  w_held_r;
    logic [AXI_ADDR_W-1:0] awaddr_r;
    logic [31:0]           wdata_r;
    logic [3:0]            wstrb_r;
    logic [1:0]            bresp_r;
    logic                  rvalid_r;
    logic [31:0]           rdata_r;
    logic [1:0]            rresp_r;

    // Effective address formation
    wire logic [7:0]  low_ofs   = op_offset;
    wire logic        low_half  = (op_offset < LOW_ACCESS_LIMIT);
    wire logic [3:0]  acc_bank  = low_half ? LOW_ACCESS_BANK
                                           : HIGH_ACCESS_BANK;
    wire logic [3:0]  dir_bank  = op_access ? bank_r : acc_bank;
    wire logic [11:0] bank_addr = {dir_bank, low_ofs};
    wire logic [11:0] op_addr   = op_full ? op_full_addr
                                          : bank_addr;

    // Target decode of the operand address
    wire logic op_ram    = is_ram(op_addr);
    wire logic op_sfr    = is_sfr(op_addr);
    wire logic op_bank   = op_sfr && (op_addr == BANK_SFR_ADDR);
    wire logic op_unimpl = !op_ram && !op_bank;
    wire logic ram_we    = op_valid && op_write && op_ram;
    wire logic bank_we   = op_valid && op_write && op_bank;

    bank_ram #(
        .DEPTH  (RAM_DEPTH),
        .ADDR_W (ADDR_W)
    ) u_ram (
        .aclk  (aclk),
        .we    (ram_we),
        .waddr (op_addr),
        .wdata (op_wdata),
        .raddr (op_addr),
        .rdata (ram_rdata)
    );

    // Bus handshake decode
    wire logic aw_fire  = s_axi_awvalid && s_axi_awready;
    wire logic w_fire   = s_axi_wvalid && s_axi_wready;
    wire logic aw_have  = aw_held_r || aw_fire;
    wire logic w_have   = w_held_r || w_fire;
    wire logic wr_go    = (wr_state_r == WR_IDLE) && aw_have && w_have;
    wire logic [AXI_ADDR_W-1:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    wire logic [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
    wire logic [3:0]  wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
    wire logic [7:0]  wr_ofs  = 8'(wr_addr);
    wire logic wr_bank  = (wr_ofs == REG_BANK_NUMBER);
    wire logic wr_ro    = (wr_ofs == REG_LAST_ACCESS) ||
                          (wr_ofs == REG_OP_COUNT);
    wire logic axi_bank_we = wr_go && wr_bank && wr_strb[0];

    // Read decode
    wire logic       ar_fire = s_axi_arvalid && s_axi_arready;
    wire logic [7:0] rd_ofs  = 8'(s_axi_araddr);
    wire logic       rd_hit  = (rd_ofs == REG_BANK_NUMBER) ||
                               (rd_ofs == REG_LAST_ACCESS) ||
                               (rd_ofs == REG_OP_COUNT);
    wire logic [31:0] rd_word =
        (rd_ofs == REG_BANK_NUMBER) ? {24'h0, 4'h0, bank_r} :
        (rd_ofs == REG_LAST_ACCESS) ? last_r :
        (rd_ofs == REG_OP_COUNT)    ? {16'h0, count_r} :
                                      32'h0000_0000;

    // Bank register source: decoder load, then data write, then bus
    always_comb begin
        bank_nxt = bank_r;
        if (load_bank_literal) begin
            bank_nxt = load_bank_value[3:0];
        end else if (bank_we) begin
            bank_nxt = op_wdata[3:0];
        end else if (axi_bank_we) begin
            bank_nxt = wr_data[3:0];
        end
    end

    // Bank register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bank_r <= BANK_NUMBER_RST[3:0];
        end else begin
            bank_r <= bank_nxt;
        end
    end

    // First answer stage: address and target captured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1_r    <= 1'b0;
            s1_ram_r    <= 1'b0;
            s1_bank_r   <= 1'b0;
            s1_unimpl_r <= 1'b0;
            eff_addr_r  <= 12'h000;
        end else begin
            stage1_r <= op_valid;
            if (op_valid) begin
                s1_ram_r    <= op_ram;
                s1_bank_r   <= op_bank;
                s1_unimpl_r <= op_unimpl;
                eff_addr_r  <= op_addr;
            end
        end
    end

    // Second stage read data: zero outside RAM and bank register
    wire logic [7:0] s2_data = s1_ram_r  ? ram_rdata :
                               s1_bank_r ? {4'h0, bank_r} :
                                           8'h00;

    // Answer registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_valid_r <= 1'b0;
            rd_data_r  <= 8'h00;
            unimpl_r   <= 1'b0;
        end else begin
            rd_valid_r <= stage1_r;
            if (stage1_r) begin
                rd_data_r <= s2_data;
                unimpl_r  <= s1_unimpl_r;
            end
        end
    end

    // Last access record and operation count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_r  <= LAST_ACCESS_RST;
            count_r <= OP_COUNT_RST;
        end else if (op_valid) begin
            last_r <= 32'h0;
            last_r[LAST_ADDR_LSB +: ADDR_W] <= op_addr;
            last_r[LAST_UNIMPL_BIT]         <= op_unimpl;
            last_r[LAST_ACCESS_BIT]         <= !op_full && !op_access;
            last_r[LAST_FULL_BIT]           <= op_full;
            last_r[LAST_WRITE_BIT]          <= op_write;
            count_r <= count_r + 16'h0001;
        end
    end

    // Write channel state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= WR_IDLE;
        end else begin
            case (wr_state_r)
                WR_IDLE: begin
                    if (wr_go) begin
                        wr_state_r <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_r <= WR_IDLE;
                    end
                end
                default: wr_state_r <= WR_IDLE;
            endcase
        end
    end

    // Address and data holding while the other half is awaited
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            aw_held_r <= aw_have && !wr_go;
            w_held_r  <= w_have && !wr_go;
            if (aw_fire) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
        end
    end

    // Write response code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bresp_r <= (wr_bank || wr_ro) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Bus outputs
    assign s_axi_awready = (wr_state_r == WR_IDLE) && !aw_held_r;
    assign s_axi_wready  = (wr_state_r == WR_IDLE) && !w_held_r;
    assign s_axi_bvalid  = (wr_state_r == WR_RESP);
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // Decoder-side outputs
    assign eff_addr    = eff_addr_r;
    assign rd_valid    = rd_valid_r;
    assign rd_data     = rd_data_r;
    assign unimpl_hit  = unimpl_r;
    assign bank_number = {4'h0, bank_r};

endmodule
`default_nettype wire

/* File: test/banked_data_address_select_checker.sv */
// Checker of operand address formation and answer timing
`timescale 1ns/100ps
`default_nettype none
module banked_data_address_select_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        op_valid,
    input wire logic        op_access,
    input wire logic [7:0]  op_offset,
    input wire logic        op_full,
    input wire logic [11:0] op_full_addr,
    input wire logic        load_bank_literal,
    input wire logic [7:0]  load_bank_value,
    input wire logic [11:0] eff_addr,
    input wire logic        rd_valid,
    input wire logic [7:0]  rd_data,
    input wire logic        unimpl_hit,
    input wire logic [7:0]  bank_number
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Request taken, one edge of address forming, then the answer
    sequence s_take;
        op_valid ##1 1'b1;
    endsequence
    sequence s_answer;
        rd_valid;
    endsequence
    a_answer_time: assert property (s_take |-> ##1 s_answer)
        else $error("operand answer late or missing");
    a_answer_cause: assert property (rd_valid |-> $past(op_valid, 2))
        else $error("answer without request");
    a_banked_addr: assert property (op_valid && op_access && !op_full |=>
        {eff_addr[7:0] == $past(op_offset)} && {4'h0, eff_addr[11:8]} == $past(bank_number))
        else $error("banked address wrong");
    a_low_access: assert property (op_valid && !op_access && !op_full && op_offset < 8'h60 |=>
        eff_addr == {4'h0, $past(op_offset)})
        else $error("low access address wrong");
    a_high_access: assert property (op_valid && !op_access && !op_full && op_offset >= 8'h60 |=>
        eff_addr == {4'hf, $past(op_offset)})
        else $error("high access address wrong");
    a_full_move: assert property (op_valid && op_full |=> eff_addr == $past(op_full_addr))
        else $error("full move address wrong");
    a_bank_upper: assert property (bank_number[7:4] == 4'h0)
        else $error("bank upper bits not zero");
    a_literal_load: assert property (load_bank_literal |=>
        bank_number == {4'h0, $past(load_bank_value[3:0])})
        else $error("bank literal not loaded");
    a_unimpl_zero: assert property (rd_valid && unimpl_hit |-> rd_data == 8'h00)
        else $error("unimplemented data not zero");
endmodule
bind banked_data_address_select banked_data_address_select_checker checker_inst (
    .aclk, .aresetn, .op_valid, .op_access, .op_offset, .op_full, .op_full_addr,
    .load_bank_literal, .load_bank_value, .eff_addr, .rd_valid, .rd_data,
    .unimpl_hit, .bank_number
);
`default_nettype wire

/* File: test/banked_data_address_select_tb.sv */
// Testbench for banked data address select
`timescale 1ns/100ps
`default_nettype none
module banked_data_address_select_tb;
    import bank_addr_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic        op_valid, op_access, op_full, op_write, load_bank_literal;
    logic [7:0]  op_offset, op_wdata, load_bank_value, rd_data, bank_number;
    logic [11:0] op_full_addr, eff_addr;
    logic        rd_valid, unimpl_hit;
    logic [31:0] d;
    logic [1:0]  r;
    int          mismatches = 0, checks = 0;
    always #2.5 aclk = ~aclk;
    banked_data_address_select banked_data_address_select_inst (
        .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .op_valid, .op_access, .op_offset, .op_full, .op_full_addr, .op_write,
        .op_wdata, .load_bank_literal, .load_bank_value, .eff_addr, .rd_valid,
        .rd_data, .unimpl_hit, .bank_number
    );
    decoder_model dec (
        .aclk, .op_valid, .op_access, .op_offset, .op_full, .op_full_addr,
        .op_write, .op_wdata, .load_bank_literal, .load_bank_value
    );
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Register bus write, each channel released when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 0;
        if (n == 100) mismatches++;
    endtask
    // Register bus read
    task automatic axr(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        d = rdata; r = rresp;
        rready <= 0;
        if (n == 100) mismatches++;
    endtask
    // Operand through decoder, address then answer
    task automatic do_op(input logic a, input logic [7:0] o, input logic f,
                         input logic [11:0] fa, input logic w, input logic [7:0] wd,
                         input logic [11:0] ea, input logic [7:0] ed, input logic eu);
        dec.op(a, o, f, fa, w, wd);
        #1 chk(eff_addr, ea);
        @(posedge aclk);
        #1 chk(rd_valid, 1'b1);
        if (!w) chk(rd_data, ed);
        chk(unimpl_hit, eu);
    endtask
    // Bank register over the bus, unmapped offset
    task automatic t_regs;
        axr(REG_BANK_NUMBER); chk(d, 32'h0);
        axw(REG_BANK_NUMBER, 32'h0000_00ab); chk(r, RESP_OKAY);
        axr(REG_BANK_NUMBER); chk(d, 32'h0000_000b);
        chk(bank_number, 8'h0b);
        axr(8'h0c); chk(r, RESP_SLVERR);
        chk(d, 32'h0);
    endtask
    // Banked access at the top offset of a bank
    task automatic t_bank;
        dec.load(8'h35); #1 chk(bank_number, 8'h05);
        do_op(1, 8'hff, 0, 0, 1, 8'h5a, 12'h5ff, 0, 0);
        do_op(1, 8'hff, 0, 0, 0, 0, 12'h5ff, 8'h5a, 0);
    endtask
    // Access bank boundary and full-address move
    task automatic t_access;
        do_op(0, 8'h5f, 0, 0, 1, 8'h11, 12'h05f, 0, 0);
        do_op(0, 8'h00, 1, 12'h05f, 0, 0, 12'h05f, 8'h11, 0);
        do_op(0, 8'h60, 0, 0, 0, 0, 12'hf60, 0, 1);
        do_op(0, 8'h80, 0, 0, 0, 0, 12'hf80, 8'h05, 0);
        do_op(0, 8'h61, 0, 0, 0, 0, 12'hf61, 0, 1);
    endtask
    // Unimplemented bank drops writes and reads zero
    task automatic t_unimpl;
        dec.load(8'h0f);
        do_op(1, 8'h10, 0, 0, 1, 8'h77, 12'hf10, 0, 1);
        do_op(1, 8'h10, 0, 0, 0, 0, 12'hf10, 0, 1);
    endtask
    // Bank register written as a data operand, then status registers over the bus
    task automatic t_status;
        do_op(0, 8'h80, 0, 0, 1, 8'h37, 12'hf80, 0, 0);
        chk(bank_number, 8'h07);
        axr(REG_LAST_ACCESS); chk(d, 32'h000a_0f80);
        chk(r, RESP_OKAY);
        axr(REG_OP_COUNT); chk(d, 32'h0000_000a);
        axw(REG_OP_COUNT, 32'h0000_0001); chk(r, RESP_OKAY);
        axw(8'h0c, 32'h0000_0003); chk(r, RESP_SLVERR);
        axr(REG_OP_COUNT); chk(d, 32'h0000_000a);
        axr(REG_BANK_NUMBER); chk(d, 32'h0000_0007);
    endtask
    // Verdict and end of run
    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog
    initial begin
        #25000;
        mismatches++;
        results;
    end
    // Main sequence
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_bank;
        t_access;
        t_unimpl;
        t_status;
        results;
    end
endmodule
`default_nettype wire

/* File: test/decoder_model.sv */
// Instruction decoder model issuing operand and bank loads
`timescale 1ns/100ps
`default_nettype none
module decoder_model (
    input  wire logic   aclk,
    output logic        op_valid,
    output logic        op_access,
    output logic [7:0]  op_offset,
    output logic        op_full,
    output logic [11:0] op_full_addr,
    output logic        op_write,
    output logic [7:0]  op_wdata,
    output logic        load_bank_literal,
    output logic [7:0]  load_bank_value
);
    // Idle decoder at time zero
    initial begin
        {op_valid, op_access, op_offset, op_full, op_full_addr} = '0;
        {op_write, op_wdata, load_bank_literal, load_bank_value} = '0;
    end
    // One operand per instruction, access bit chosen per word
    task automatic op(input logic a, input logic [7:0] o, input logic f,
                      input logic [11:0] fa, input logic w, input logic [7:0] d);
        @(posedge aclk);
        op_valid <= 1'b1;
        op_access <= a;
        op_offset <= o;
        op_full <= f;
        op_full_addr <= fa;
        op_write <= w;
        op_wdata <= d;
        @(posedge aclk);
        op_valid <= 1'b0;
    endtask
    // Bank number loaded before banked operands
    task automatic load(input logic [7:0] v);
        @(posedge aclk);
        load_bank_literal <= 1'b1;
        load_bank_value <= v;
        @(posedge aclk);
        load_bank_literal <= 1'b0;
    endtask
endmodule
`default_nettype wire
